// *** src/intr_capture_pkg.sv ***
// Purpose: Shared constants and carrier types for interruption state capture.
// Assumes: 32-bit APB register access, each 64-bit register as two words.
// Notes: Offsets are byte addresses.
`default_nettype none
package intr_capture_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_RESUME_LO = 8'h00;
    localparam logic [7:0] OFF_RESUME_HI = 8'h04;
    localparam logic [7:0] OFF_FAULT_LO = 8'h08;
    localparam logic [7:0] OFF_FAULT_HI = 8'h0C;
    localparam logic [7:0] OFF_INSERT_LO = 8'h10;
    localparam logic [7:0] OFF_INSERT_HI = 8'h14;
    localparam logic [7:0] OFF_PREV_LO = 8'h18;
    localparam logic [7:0] OFF_PREV_HI = 8'h1C;
    localparam logic [7:0] OFF_FRAME_LO = 8'h20;
    localparam logic [7:0] OFF_FRAME_HI = 8'h24;
    localparam logic [7:0] OFF_STATUS = 8'h28;

    // ------------------------------------------------------------------
    // Field layout and widths
    // ------------------------------------------------------------------
    localparam int PAGE_SIZE_LSB = 2;
    localparam int PAGE_SIZE_W = 6;
    localparam int PROT_TAG_LSB = 8;
    localparam int PROT_TAG_W = 24;
    localparam int FRAME_OK_BIT = 63;
    localparam int FRAME_MARKER_W = 38;
    localparam int VIRT_IMPL_MSB = 50;
    localparam int PHYS_IMPL_MSB = 49;
    localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [63:0] BUNDLE_MASK = 64'hFFFF_FFFF_FFFF_FFF0;
    localparam logic [63:0] LOW32_MASK = 64'h0000_0000_FFFF_FFFF;
    localparam logic [63:0] RSVD_INS_MASK = 64'hFFFF_FFFF_0000_0003;

    typedef enum logic [2:0] {
        EV_FAULT,
        EV_TRAP,
        EV_EXT_INTR,
        EV_BRANCH_TRAP,
        EV_UNIMPL_VIRT,
        EV_UNIMPL_PHYS
    } intr_kind_e;

    // Interruption event from the pipeline.
    typedef struct packed {
        logic valid;
        intr_kind_e kind;
        logic [63:0] instr_ptr;
        logic [63:0] next_ptr;
        logic [63:0] fault_addr;
        logic data_ref;
        logic xlate_fault;
        logic legacy;
        logic second_page;
        logic [63:0] second_page_addr;
        logic [63:0] branch_bundle;
        logic from_return;
        logic [PAGE_SIZE_W-1:0] region_page_size;
        logic [PROT_TAG_W-1:0] region_ident;
    } intr_event_s;

    // Retirement of one instruction.
    typedef struct packed {
        logic valid;
        logic [63:0] addr;
        logic legacy;
    } retire_s;

endpackage
`default_nettype wire

// *** src/interruption_state_capture.sv ***
// Purpose: Captures processor state into five interruption registers.
// Assumes: Pipeline events are synchronous to core_clk.
// Notes: Software moves arrive as APB accesses with a privilege level.
`default_nettype none

module interruption_state_capture (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] priv_level,
    input wire logic state_collect_bit,
    input wire intr_capture_pkg::intr_event_s intr_event,
    input wire intr_capture_pkg::retire_s retire,
    input wire logic return_from_intr,
    input wire logic saved_iset_bit,
    input wire logic frame_save_instr,
    input wire logic [37:0] current_frame_marker,
    input wire logic tlb_insert,
    output logic [63:0] return_target,
    output logic [63:0] insert_vaddr,
    output logic insert_rsvd_fault,
    output logic illegal_op_fault,
    output logic priv_op_fault
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [63:0] resume_reg;
    logic [63:0] fault_reg;
    logic [63:0] insert_reg;
    logic [63:0] prev_reg;
    logic [63:0] frame_reg;
    logic [63:0] last_done_reg;
    logic last_valid_reg;
    logic [63:0] resume_next;
    logic [63:0] fault_next;
    logic capture;
    logic apb_access;
    logic apb_wr;
    logic prev_sel;
    logic frame_sel;
    logic prev_bad;
    logic frame_bad;
    logic mapped;
    logic [31:0] rd_word;

    assign capture = intr_event.valid && state_collect_bit;
    assign apb_access = psel && penable;
    assign prev_sel = (paddr == intr_capture_pkg::OFF_PREV_LO)
        || (paddr == intr_capture_pkg::OFF_PREV_HI);
    assign frame_sel = (paddr == intr_capture_pkg::OFF_FRAME_LO)
        || (paddr == intr_capture_pkg::OFF_FRAME_HI);
    assign prev_bad = prev_sel && state_collect_bit;
    assign frame_bad = frame_sel
        && (state_collect_bit || priv_level != 2'd0);
    assign apb_wr = apb_access && pwrite && mapped && !prev_bad && !frame_bad;

    // ------------------------------------------------------------------
    // Resume pointer value
    // ------------------------------------------------------------------
    always_comb begin
        resume_next = intr_event.instr_ptr;
        case (intr_event.kind)
            intr_capture_pkg::EV_TRAP,
            intr_capture_pkg::EV_EXT_INTR,
            intr_capture_pkg::EV_BRANCH_TRAP: begin
                resume_next = intr_event.next_ptr;
            end
            intr_capture_pkg::EV_UNIMPL_VIRT: begin
                resume_next = intr_event.instr_ptr;
            end
            intr_capture_pkg::EV_UNIMPL_PHYS: begin
                resume_next = intr_event.instr_ptr
                    & ~((64'h7FFF_FFFF_FFFF_FFFF
                    >> (intr_capture_pkg::PHYS_IMPL_MSB + 1))
                    << (intr_capture_pkg::PHYS_IMPL_MSB + 1));
            end
            default: begin
                resume_next = intr_event.instr_ptr;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Fault address value
    // ------------------------------------------------------------------
    always_comb begin
        if (intr_event.data_ref) begin
            fault_next = intr_event.fault_addr;
        end else if (intr_event.legacy && intr_event.second_page) begin
            fault_next = intr_event.second_page_addr
                & intr_capture_pkg::BUNDLE_MASK;
        end else begin
            fault_next = intr_event.fault_addr
                & intr_capture_pkg::BUNDLE_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Resume pointer register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            resume_reg <= intr_capture_pkg::REG_RESET;
        end else if (capture) begin
            if (!(intr_event.from_return
                && (intr_event.kind == intr_capture_pkg::EV_UNIMPL_VIRT
                || intr_event.kind == intr_capture_pkg::EV_UNIMPL_PHYS))) begin
                resume_reg <= resume_next;
            end
        end else if (apb_wr && paddr == intr_capture_pkg::OFF_RESUME_LO) begin
            resume_reg[31:0] <= pwdata;
        end else if (apb_wr && paddr == intr_capture_pkg::OFF_RESUME_HI) begin
            resume_reg[63:32] <= pwdata;
        end
    end

    // ------------------------------------------------------------------
    // Fault address register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fault_reg <= intr_capture_pkg::REG_RESET;
        end else if (capture) begin
            fault_reg <= fault_next;
        end else if (apb_wr && paddr == intr_capture_pkg::OFF_FAULT_LO) begin
            fault_reg[31:0] <= pwdata;
        end else if (apb_wr && paddr == intr_capture_pkg::OFF_FAULT_HI) begin
            fault_reg[63:32] <= pwdata;
        end
    end

    // ------------------------------------------------------------------
    // Insertion information register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            insert_reg <= intr_capture_pkg::REG_RESET;
        end else if (capture && intr_event.xlate_fault) begin
            insert_reg[7:2] <= intr_event.region_page_size;
            insert_reg[31:8] <= intr_event.region_ident;
        end else if (apb_wr && paddr == intr_capture_pkg::OFF_INSERT_LO) begin
            insert_reg[31:0] <= pwdata;
        end else if (apb_wr && paddr == intr_capture_pkg::OFF_INSERT_HI) begin
            insert_reg[63:32] <= pwdata;
        end
    end

    // ------------------------------------------------------------------
    // Last completed instruction and previous address register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            last_done_reg <= intr_capture_pkg::REG_RESET;
            last_valid_reg <= 1'b0;
        end else if (capture || return_from_intr) begin
            last_valid_reg <= 1'b0;
        end else if (retire.valid && state_collect_bit) begin
            last_done_reg <= retire.addr;
            last_valid_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_reg <= intr_capture_pkg::REG_RESET;
        end else if (capture) begin
            if (intr_event.legacy
                && intr_event.kind == intr_capture_pkg::EV_FAULT) begin
                prev_reg <= intr_event.instr_ptr;
            end else if (intr_event.kind
                == intr_capture_pkg::EV_BRANCH_TRAP) begin
                prev_reg <= intr_event.branch_bundle;
            end else if (last_valid_reg) begin
                prev_reg <= last_done_reg;
            end
        end else if (apb_wr && paddr == intr_capture_pkg::OFF_PREV_LO) begin
            prev_reg[31:0] <= pwdata;
        end else if (apb_wr && paddr == intr_capture_pkg::OFF_PREV_HI) begin
            prev_reg[63:32] <= pwdata;
        end
    end

    // ------------------------------------------------------------------
    // Saved frame register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            frame_reg <= intr_capture_pkg::REG_RESET;
        end else if (capture) begin
            frame_reg[intr_capture_pkg::FRAME_OK_BIT] <= 1'b0;
        end else if (frame_save_instr && !state_collect_bit) begin
            frame_reg[37:0] <= current_frame_marker;
            frame_reg[intr_capture_pkg::FRAME_OK_BIT] <= 1'b1;
        end else if (apb_wr && paddr == intr_capture_pkg::OFF_FRAME_LO) begin
            frame_reg[31:0] <= pwdata;
        end else if (apb_wr && paddr == intr_capture_pkg::OFF_FRAME_HI) begin
            frame_reg[63:32] <= pwdata;
        end
    end

    // ------------------------------------------------------------------
    // Return and insertion outputs
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            return_target <= intr_capture_pkg::REG_RESET;
            insert_vaddr <= intr_capture_pkg::REG_RESET;
            insert_rsvd_fault <= 1'b0;
        end else begin
            if (return_from_intr) begin
                return_target <= saved_iset_bit
                    ? (resume_reg & intr_capture_pkg::LOW32_MASK)
                    : (resume_reg & intr_capture_pkg::BUNDLE_MASK);
            end
            if (tlb_insert) begin
                insert_vaddr <= fault_reg;
            end
            insert_rsvd_fault <= tlb_insert
                && |(insert_reg & intr_capture_pkg::RSVD_INS_MASK);
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    always_comb begin
        mapped = 1'b1;
        rd_word = intr_capture_pkg::WORD_ZERO;
        case (paddr)
            intr_capture_pkg::OFF_RESUME_LO: rd_word = resume_reg[31:0];
            intr_capture_pkg::OFF_RESUME_HI: rd_word = resume_reg[63:32];
            intr_capture_pkg::OFF_FAULT_LO: rd_word = fault_reg[31:0];
            intr_capture_pkg::OFF_FAULT_HI: rd_word = fault_reg[63:32];
            intr_capture_pkg::OFF_INSERT_LO: rd_word = insert_reg[31:0];
            intr_capture_pkg::OFF_INSERT_HI: rd_word = insert_reg[63:32];
            intr_capture_pkg::OFF_PREV_LO: rd_word = prev_reg[31:0];
            intr_capture_pkg::OFF_PREV_HI: rd_word = prev_reg[63:32];
            intr_capture_pkg::OFF_FRAME_LO: rd_word = frame_reg[31:0];
            intr_capture_pkg::OFF_FRAME_HI: rd_word = frame_reg[63:32];
            intr_capture_pkg::OFF_STATUS: rd_word = {30'd0, last_valid_reg,
                state_collect_bit};
            default: mapped = 1'b0;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = apb_access && (!mapped || prev_bad || frame_bad);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata <= intr_capture_pkg::WORD_ZERO;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_word;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            illegal_op_fault <= 1'b0;
            priv_op_fault <= 1'b0;
        end else begin
            illegal_op_fault <= apb_access && frame_sel == 1'b0 && prev_bad
                || apb_access && frame_sel && state_collect_bit;
            priv_op_fault <= apb_access && frame_sel && !state_collect_bit
                && priv_level != 2'd0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_capture;
        intr_event.valid && state_collect_bit;
    endsequence

    a_frame_ok_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        s_capture |=> !frame_reg[63])
        else $error("frame ok bit not cleared");
    a_frame_save_set: assert property (
        @(posedge core_clk) disable iff (rst)
        frame_save_instr && !state_collect_bit && !intr_event.valid
        |=> frame_reg[63] && frame_reg[37:0] == $past(current_frame_marker))
        else $error("frame save failed");
    a_no_capture_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        intr_event.valid && !state_collect_bit && !psel
        |=> $stable(fault_reg) && $stable(resume_reg))
        else $error("capture registers changed with collection off");
    a_fault_data_addr: assert property (
        @(posedge core_clk) disable iff (rst)
        s_capture ##0 intr_event.data_ref
        |=> fault_reg == $past(intr_event.fault_addr))
        else $error("data fault address wrong");
    a_fault_bundle_al: assert property (
        @(posedge core_clk) disable iff (rst)
        s_capture ##0 !intr_event.data_ref |=> fault_reg[3:0] == 4'h0)
        else $error("fetch fault address not aligned");
    a_resume_fault_ip: assert property (
        @(posedge core_clk) disable iff (rst)
        s_capture ##0 intr_event.kind == intr_capture_pkg::EV_FAULT
        |=> resume_reg == $past(intr_event.instr_ptr))
        else $error("resume pointer wrong on fault");
    a_prev_access_bad: assert property (
        @(posedge core_clk) disable iff (rst)
        psel && penable && prev_sel && state_collect_bit
        |-> pslverr ##1 illegal_op_fault)
        else $error("previous address access not refused");
    a_frame_priv_bad: assert property (
        @(posedge core_clk) disable iff (rst)
        psel && penable && frame_sel && !state_collect_bit
        && priv_level != 2'd0 |=> priv_op_fault)
        else $error("frame privilege fault missing");
    a_insert_page_sz: assert property (
        @(posedge core_clk) disable iff (rst)
        s_capture ##0 intr_event.xlate_fault
        |=> insert_reg[7:2] == $past(intr_event.region_page_size)
        && insert_reg[31:8] == $past(intr_event.region_ident))
        else $error("insertion info not loaded");
    a_return_iset: assert property (
        @(posedge core_clk) disable iff (rst)
        return_from_intr && saved_iset_bit
        |=> return_target[63:32] == 32'h0000_0000)
        else $error("return upper bits not ignored");
    a_prev_legacy: assert property (
        @(posedge core_clk) disable iff (rst)
        s_capture ##0 (intr_event.legacy
        && intr_event.kind == intr_capture_pkg::EV_FAULT)
        |=> prev_reg == $past(intr_event.instr_ptr))
        else $error("legacy fault previous address wrong");
    a_prev_branch: assert property (
        @(posedge core_clk) disable iff (rst)
        s_capture ##0 intr_event.kind == intr_capture_pkg::EV_BRANCH_TRAP
        |=> prev_reg == $past(intr_event.branch_bundle)
        && resume_reg == $past(intr_event.next_ptr))
        else $error("branch trap addresses wrong");
    a_resume_kept: assert property (
        @(posedge core_clk) disable iff (rst)
        s_capture ##0 (intr_event.from_return
        && intr_event.kind == intr_capture_pkg::EV_UNIMPL_VIRT)
        |=> $stable(resume_reg))
        else $error("resume pointer rewritten on return trap");
    a_insert_vaddr: assert property (
        @(posedge core_clk) disable iff (rst)
        tlb_insert |=> insert_vaddr == $past(fault_reg))
        else $error("insertion address not taken from fault address");

endmodule
`default_nettype wire

// *** sim/interruption_state_capture_tb_top.sv ***
// Purpose: Self-checking bench for the interruption state capture block.
// Assumes: Zero-wait APB slave; pipeline events are one-cycle pulses.
// Notes: Each 64-bit register is reached as a low and a high word.
`default_nettype none
module interruption_state_capture_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] priv_level;
    logic state_collect_bit, return_from_intr, saved_iset_bit;
    logic frame_save_instr, tlb_insert, insert_rsvd_fault;
    logic illegal_op_fault, priv_op_fault, err, ill, prv;
    logic [37:0] current_frame_marker;
    logic [2:0] ev_flags = 3'b000;
    logic [63:0] return_target, insert_vaddr, v;
    intr_capture_pkg::intr_event_s intr_event;
    intr_capture_pkg::retire_s retire;
    int n_errors = 0;
    int check_count = 0;

    interruption_state_capture DUT (.core_clk(core_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .priv_level(priv_level),
        .state_collect_bit(state_collect_bit), .intr_event(intr_event),
        .retire(retire), .return_from_intr(return_from_intr),
        .saved_iset_bit(saved_iset_bit),
        .frame_save_instr(frame_save_instr),
        .current_frame_marker(current_frame_marker),
        .tlb_insert(tlb_insert), .return_target(return_target),
        .insert_vaddr(insert_vaddr),
        .insert_rsvd_fault(insert_rsvd_fault),
        .illegal_op_fault(illegal_op_fault),
        .priv_op_fault(priv_op_fault));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [63:0] seen,
                       input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (n_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
        ill = illegal_op_fault;
        prv = priv_op_fault;
    endtask

    task automatic rd64(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
        v[31:0] = rd;
        apb(1'b0, 8'(a + 8'h04), 32'h0000_0000);
        v[63:32] = rd;
    endtask

    task automatic wr64(input logic [7:0] a, input logic [63:0] d);
        apb(1'b1, a, d[31:0]);
        apb(1'b1, 8'(a + 8'h04), d[63:32]);
    endtask

    task automatic fire(input intr_capture_pkg::intr_kind_e k,
                        input logic [63:0] ip, input logic [63:0] fa,
                        input logic dr);
        intr_capture_pkg::intr_event_s e;
        e = '0;
        e.valid = 1'b1;
        e.kind = k;
        e.instr_ptr = ip;
        e.next_ptr = ip + 64'h0000_0000_0000_0010;
        e.fault_addr = fa;
        e.data_ref = dr;
        e.xlate_fault = 1'b1;
        e.region_page_size = 6'h0E;
        e.region_ident = 24'hAB_CDEF;
        e.legacy = ev_flags[2];
        e.second_page = ev_flags[1];
        e.from_return = ev_flags[0];
        e.second_page_addr = fa + 64'h0000_0000_0000_1000;
        e.branch_bundle = fa;
        @(posedge core_clk);
        intr_event <= e;
        @(posedge core_clk);
        intr_event <= '0;
    endtask

    task automatic pulse_insert();
        @(posedge core_clk);
        tlb_insert <= 1'b1;
        @(posedge core_clk);
        tlb_insert <= 1'b0;
        @(posedge core_clk);
    endtask

    initial begin
        #50000;
        n_errors++;
        give_verdict();
    end
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, priv_level} = '0;
        {state_collect_bit, return_from_intr, saved_iset_bit} = '0;
        {frame_save_instr, current_frame_marker, tlb_insert} = '0;
        intr_event = '0;
        retire = '0;
        rst = 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rd64(intr_capture_pkg::OFF_RESUME_LO);
        chk("resume_reset", v, 64'h0000_0000_0000_0000);
        state_collect_bit <= 1'b1;
        fire(intr_capture_pkg::EV_FAULT, 64'h2000_0000_0000_1230,
             64'h0000_0000_0000_4567, 1'b1);
        rd64(intr_capture_pkg::OFF_RESUME_LO);
        chk("resume_fault", v, 64'h2000_0000_0000_1230);
        rd64(intr_capture_pkg::OFF_FAULT_LO);
        chk("fault_data", v, 64'h0000_0000_0000_4567);
        rd64(intr_capture_pkg::OFF_INSERT_LO);
        chk("insert_fields", v[31:2], {24'hAB_CDEF, 6'h0E});
        fire(intr_capture_pkg::EV_FAULT, 64'h0000_0000_0000_2000,
             64'h0000_0000_0000_89AB, 1'b0);
        rd64(intr_capture_pkg::OFF_FAULT_LO);
        chk("fault_bundle", v, 64'h0000_0000_0000_89A0);
        for (int i = 0; i < 2; i++) begin
            fire(i == 0 ? intr_capture_pkg::EV_TRAP :
                 intr_capture_pkg::EV_EXT_INTR, 64'h0000_0000_0000_3000,
                 64'h0000_0000_0000_0000, 1'b0);
            rd64(intr_capture_pkg::OFF_RESUME_LO);
            chk("resume_next", v, 64'h0000_0000_0000_3010);
        end
        @(posedge core_clk);
        retire <= '{1'b1, 64'h0000_0000_0000_5550, 1'b0};
        @(posedge core_clk);
        retire <= '0;
        fire(intr_capture_pkg::EV_TRAP, 64'h0000_0000_0000_5560,
             64'h0000_0000_0000_0000, 1'b0);
        apb(1'b0, intr_capture_pkg::OFF_PREV_LO, 32'h0000_0000);
        chk("prev_refused", {err, ill}, 2'b11);
        state_collect_bit <= 1'b0;
        rd64(intr_capture_pkg::OFF_PREV_LO);
        chk("prev_retired", v, 64'h0000_0000_0000_5550);
        rd64(intr_capture_pkg::OFF_FRAME_LO);
        chk("frame_ok_clear", v[63], 1'b0);
        fire(intr_capture_pkg::EV_FAULT, 64'h0000_0000_0000_7770,
             64'h0000_0000_0000_7777, 1'b1);
        rd64(intr_capture_pkg::OFF_RESUME_LO);
        chk("resume_kept", v, 64'h0000_0000_0000_5570);
        wr64(intr_capture_pkg::OFF_PREV_LO, 64'h0000_0000_0000_6660);
        @(posedge core_clk);
        frame_save_instr <= 1'b1;
        current_frame_marker <= 38'h3A_BCDE_F012;
        @(posedge core_clk);
        frame_save_instr <= 1'b0;
        rd64(intr_capture_pkg::OFF_FRAME_LO);
        chk("frame_save", {v[63], v[37:0]}, {1'b1, 38'h3A_BCDE_F012});
        priv_level <= 2'b01;
        apb(1'b0, intr_capture_pkg::OFF_FRAME_LO, 32'h0000_0000);
        chk("frame_priv", {err, prv}, 2'b11);
        priv_level <= 2'b00;
        state_collect_bit <= 1'b1;
        fire(intr_capture_pkg::EV_FAULT, 64'h0000_0000_0000_8880,
             64'h0000_0000_0000_8888, 1'b1);
        fire(intr_capture_pkg::EV_UNIMPL_PHYS, 64'hFFFF_FFFF_FFFF_FFF0,
             64'h0000_0000_0000_0000, 1'b0);
        rd64(intr_capture_pkg::OFF_RESUME_LO);
        chk("resume_phys", v, 64'h8003_FFFF_FFFF_FFF0);
        fire(intr_capture_pkg::EV_UNIMPL_VIRT, 64'h1234_5678_9ABC_DEF0,
             64'h0000_0000_0000_0000, 1'b0);
        rd64(intr_capture_pkg::OFF_RESUME_LO);
        chk("resume_virt", v, 64'h1234_5678_9ABC_DEF0);
        state_collect_bit <= 1'b0;
        rd64(intr_capture_pkg::OFF_PREV_LO);
        chk("prev_unchanged", v, 64'h0000_0000_0000_6660);
        state_collect_bit <= 1'b1;
        ev_flags = 3'b110;
        fire(intr_capture_pkg::EV_FAULT, 64'h0000_0000_0000_4443,
             64'h0000_0000_0000_4448, 1'b0);
        rd64(intr_capture_pkg::OFF_FAULT_LO);
        chk("fault_page2", v, 64'h0000_0000_0000_5440);
        ev_flags = 3'b001;
        fire(intr_capture_pkg::EV_UNIMPL_VIRT, 64'h0000_0000_0000_9993,
             64'h0000_0000_0000_0000, 1'b0);
        rd64(intr_capture_pkg::OFF_RESUME_LO);
        chk("resume_held", v, 64'h0000_0000_0000_4443);
        ev_flags = 3'b000;
        fire(intr_capture_pkg::EV_BRANCH_TRAP, 64'h0000_0000_0000_9990,
             64'h0000_0000_0000_7770, 1'b0);
        rd64(intr_capture_pkg::OFF_RESUME_LO);
        chk("resume_target", v, 64'h0000_0000_0000_99A0);
        state_collect_bit <= 1'b0;
        rd64(intr_capture_pkg::OFF_PREV_LO);
        chk("prev_branch", v, 64'h0000_0000_0000_7770);
        wr64(intr_capture_pkg::OFF_RESUME_LO, 64'hABCD_0000_1234_567F);
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            return_from_intr <= 1'b1;
            saved_iset_bit <= i[0];
            @(posedge core_clk);
            return_from_intr <= 1'b0;
            @(posedge core_clk);
            chk("return_target", return_target, i == 0 ?
                64'hABCD_0000_1234_5670 : 64'h0000_0000_1234_567F);
        end
        wr64(intr_capture_pkg::OFF_FAULT_LO, 64'h0000_7000_0000_1000);
        wr64(intr_capture_pkg::OFF_INSERT_LO, 64'h0000_0000_0000_0000);
        pulse_insert();
        chk("insert_vaddr", insert_vaddr, 64'h0000_7000_0000_1000);
        chk("insert_clean", insert_rsvd_fault, 1'b0);
        apb(1'b1, intr_capture_pkg::OFF_INSERT_HI, 32'h0000_0001);
        pulse_insert();
        chk("insert_rsvd", insert_rsvd_fault, 1'b1);
        apb(1'b0, 8'h3C, 32'h0000_0000);
        chk("unmapped", err, 1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
